//--- design/dmc_channels.sv
// dmc: four dma channel register sets with axi4-lite access and strobes
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_channels #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic standby_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] external_transfer_request_b_i,
  output logic [1:0] acknowledge_strobe_o,
  output logic [1:0] request_accepted_output_o,
  input wire logic [3:0] periph_req_i,
  input wire logic [3:0] rd_cycle_i,
  input wire logic [3:0] wr_cycle_i,
  input wire logic [3:0] xfer_done_i,
  output logic [3:0] chan_req_o,
  output logic [3:0][31:0] src_addr_o,
  output logic [3:0][31:0] dst_addr_o
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 8) begin : g_chk
    $error("dmc_channels needs ADDR_W of at least 8");
  end
  dmc_pkg::dmc_state_type st_ff;
  dmc_pkg::dmc_state_type nxt_st;
  logic [3:0][31:0] stp_sar;
  logic [3:0][31:0] stp_dar;
  logic [3:0][23:0] stp_tcr;
  logic [3:0] stp_last;
  logic [3:0] stp_reload;
  logic [3:0][31:0] wmask;
  logic [3:0] ext_sel;
  logic [3:0] live;
  logic do_wr;
  logic do_rd;
  logic [1:0] wch;
  logic [1:0] wreg;
  logic wmap;
  // ---------------------------------------------------------------
  // per channel step units and static masks
  // ---------------------------------------------------------------
  for (genvar c = 0; c < 4; c++) begin : g_ch
    // absent bits read zero and cannot be written
    assign wmask[c] = `DMC_MSK_BASE |
        ((c < `DMC_EXT_CHANNELS) ? `DMC_MSK_EXT : `DMC_STEP_0) |
        ((c == `DMC_RELOAD_CH) ? `DMC_MSK_CH2 : `DMC_STEP_0) |
        ((c == `DMC_INDIRECT_CH) ? `DMC_MSK_CH3 : `DMC_STEP_0);
    // every fourth transfer on the reload channel restores the source
    assign stp_reload[c] = (c == `DMC_RELOAD_CH) &&
        st_ff.ch[c].ctl[`DMC_B_RO] && (st_ff.rl_cnt == `DMC_RELOAD_LAST);
    assign ext_sel[c] = (c < `DMC_EXT_CHANNELS) &&
        (st_ff.ch[c].ctl[`DMC_F_RS] == `DMC_RS_EXT_DUAL ||
         st_ff.ch[c].ctl[`DMC_F_RS] == `DMC_RS_SGL_TO_DEV ||
         st_ff.ch[c].ctl[`DMC_F_RS] == `DMC_RS_SGL_FROM_DEV);
    assign live[c] = st_ff.ch[c].ctl[`DMC_B_DE] & ~st_ff.ch[c].ctl[`DMC_B_TE];
    // request towards the bus sequencer
    assign chan_req_o[c] = live[c] & (ext_sel[c] ? st_ff.ch[c].ext_pend :
        ((st_ff.ch[c].ctl[`DMC_F_RS] == `DMC_RS_AUTO) | periph_req_i[c]));
    assign src_addr_o[c] = st_ff.ch[c].source_address;
    assign dst_addr_o[c] = st_ff.ch[c].destination_address;
    dmc_step #(
      .CH(c)
    ) u_step (
      .ctl_i(st_ff.ch[c].ctl),
      .sar_i(st_ff.ch[c].source_address),
      .dar_i(st_ff.ch[c].destination_address),
      .tcr_i(st_ff.ch[c].tcr),
      .reload_i(stp_reload[c]),
      .reload_sar_i(st_ff.rl_sar),
      .sar_o(stp_sar[c]),
      .dar_o(stp_dar[c]),
      .tcr_o(stp_tcr[c]),
      .last_o(stp_last[c])
    );
  end
  // ---------------------------------------------------------------
  // bus side handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready_o = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready_o = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready_o = ~st_ff.rvalid;
  assign s_axi_bvalid_o = st_ff.bvalid;
  assign s_axi_bresp_o = st_ff.bresp;
  assign s_axi_rvalid_o = st_ff.rvalid;
  assign s_axi_rresp_o = st_ff.rresp;
  assign s_axi_rdata_o = st_ff.rdata;
  assign acknowledge_strobe_o = st_ff.ack;
  assign request_accepted_output_o = st_ff.request_accepted_output;
  assign do_wr = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
  assign do_rd = s_axi_arvalid_i & ~st_ff.rvalid;
  assign wmap = (st_ff.awaddr[`DMC_F_WIN] == `DMC_WIN_TAG);
  assign wch = st_ff.awaddr[`DMC_F_CH];
  assign wreg = st_ff.awaddr[`DMC_F_REG];
  // byte lane merge of a write word
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic [31:0] cv;
    logic hit;
    logic te_set;
    logic te_clr;
    logic act;
    logic det;
    logic [7:0] ra;
    wv = 32'h00000000;
    rv = 32'h00000000;
    cv = 32'h00000000;
    hit = 1'b0;
    te_set = 1'b0;
    te_clr = 1'b0;
    act = 1'b0;
    det = 1'b0;
    ra = s_axi_araddr_i[7:0];
    nxt_st = st_ff;
    // request pins pass two flops, kept active high so reset reads idle
    nxt_st.req_s1 = ~external_transfer_request_b_i;
    nxt_st.req_s2 = st_ff.req_s1;
    nxt_st.req_s3 = st_ff.req_s2;
    // address and data channels taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr_i[7:0];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata_i;
      nxt_st.wstrb = s_axi_wstrb_i;
    end
    if (st_ff.bvalid && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wmap ? `DMC_RESP_OK : `DMC_RESP_ERR;
    end
    if (st_ff.rvalid && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    for (int c = 0; c < 4; c++) begin
      hit = do_wr && wmap && (wch == c[1:0]);
      // transfer unit finished: count addresses and length
      te_set = 1'b0;
      if (xfer_done_i[c] && live[c]) begin
        nxt_st.ch[c].source_address = stp_sar[c];
        nxt_st.ch[c].destination_address = stp_dar[c];
        nxt_st.ch[c].tcr = stp_tcr[c];
        nxt_st.ch[c].ext_pend = 1'b0;
        te_set = stp_last[c];
        if (c == `DMC_RELOAD_CH) begin
          nxt_st.rl_cnt = st_ff.rl_cnt + 2'h1;
        end
      end
      // software write overrides hardware counting on the same word
      wv = 32'h00000000;
      case (wreg)
        `DMC_REG_SAR: wv = st_ff.ch[c].source_address;
        `DMC_REG_DAR: wv = st_ff.ch[c].destination_address;
        `DMC_REG_TCR: wv = {`DMC_TCR_HI_ZERO, st_ff.ch[c].tcr};
        default: wv = st_ff.ch[c].ctl;
      endcase
      wv = merge(wv, st_ff.wdata, st_ff.wstrb);
      if (hit && wreg == `DMC_REG_SAR) begin
        nxt_st.ch[c].source_address = wv;
        if (c == `DMC_RELOAD_CH) begin
          nxt_st.rl_sar = wv;
          nxt_st.rl_cnt = 2'h0;
        end
      end
      if (hit && wreg == `DMC_REG_DAR) begin
        nxt_st.ch[c].destination_address = wv;
      end
      if (hit && wreg == `DMC_REG_TCR) begin
        nxt_st.ch[c].tcr = wv[23:0];
      end
      // outside standby the flag clears only by a zero after it was seen as one
      te_clr = hit && (wreg == `DMC_REG_CTL) && st_ff.wstrb[0] &&
               ~st_ff.wdata[`DMC_B_TE] && st_ff.ch[c].te_seen;
      cv = st_ff.ch[c].ctl;
      if (hit && wreg == `DMC_REG_CTL) begin
        cv = (cv & ~wmask[c]) | (wv & wmask[c]);
      end
      // set wins over clear in the same cycle
      cv[`DMC_B_TE] = te_set | (st_ff.ch[c].ctl[`DMC_B_TE] & ~te_clr);
      nxt_st.ch[c].ctl = cv;
      if (~cv[`DMC_B_TE]) begin
        nxt_st.ch[c].te_seen = 1'b0;
      end
      // external request detection and accept strobe
      if (c < `DMC_EXT_CHANNELS) begin
        det = st_ff.ch[c].ctl[`DMC_B_DS] ?
              (st_ff.req_s2[c] & ~st_ff.req_s3[c]) : st_ff.req_s2[c];
        act = live[c] & ext_sel[c] & ~st_ff.ch[c].ext_pend & det;
        if (act) begin
          nxt_st.ch[c].ext_pend = 1'b1;
        end
        nxt_st.request_accepted_output[c] = act ^ st_ff.ch[c].ctl[`DMC_B_RL];
        // acknowledge timing by mode, then polarity
        if (st_ff.ch[c].ctl[`DMC_F_RS] == `DMC_RS_SGL_TO_DEV ||
            st_ff.ch[c].ctl[`DMC_F_RS] == `DMC_RS_SGL_FROM_DEV) begin
          act = rd_cycle_i[c] | wr_cycle_i[c];
        end else begin
          act = st_ff.ch[c].ctl[`DMC_B_AM] ? wr_cycle_i[c] :
                rd_cycle_i[c];
        end
        act = act & st_ff.ch[c].ctl[`DMC_B_DE];
        nxt_st.ack[c] = act ^ st_ff.ch[c].ctl[`DMC_B_AL];
      end
    end
    // read answer one cycle after the address is taken
    if (do_rd) begin
      rv = 32'h00000000;
      case (ra[`DMC_F_REG])
        `DMC_REG_SAR: rv = st_ff.ch[ra[`DMC_F_CH]].source_address;
        `DMC_REG_DAR: rv = st_ff.ch[ra[`DMC_F_CH]].destination_address;
        `DMC_REG_TCR: rv = {`DMC_TCR_HI_ZERO,
                            st_ff.ch[ra[`DMC_F_CH]].tcr};
        default: rv = st_ff.ch[ra[`DMC_F_CH]].ctl;
      endcase
      nxt_st.rvalid = 1'b1;
      nxt_st.raddr = ra;
      nxt_st.rdata = (ra[`DMC_F_WIN] == `DMC_WIN_TAG) ? rv : 32'h00000000;
      nxt_st.rresp = (ra[`DMC_F_WIN] == `DMC_WIN_TAG) ? `DMC_RESP_OK :
                     `DMC_RESP_ERR;
      if (ra[`DMC_F_WIN] == `DMC_WIN_TAG && ra[`DMC_F_REG] == `DMC_REG_CTL &&
          rv[`DMC_B_TE]) begin
        nxt_st.ch[ra[`DMC_F_CH]].te_seen = 1'b1;
      end
    end
    // standby clears channel control, keeps addresses and counts
    if (standby_i) begin
      for (int c = 0; c < 4; c++) begin
        nxt_st.ch[c].ctl = `DMC_CTL_RST;
        nxt_st.ch[c].te_seen = 1'b0;
        nxt_st.ch[c].ext_pend = 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ---------------------------------------------------------------
  // assertions on channel 0, absent control bits of all channels, and the bus
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_TE_ON_LAST: assert property (
    (xfer_done_i[0] && live[0] && st_ff.ch[0].tcr == 24'h000001 &&
     !standby_i) |=> st_ff.ch[0].ctl[1])
    else $error("flag not set after last unit");
  AST_ZERO_WRAPS: assert property (
    (xfer_done_i[0] && live[0] && st_ff.ch[0].tcr == 24'h000000 &&
     !(do_wr && wmap && wch == 2'h0)) |=>
    (st_ff.ch[0].tcr == 24'hffffff && !st_ff.ch[0].ctl[1]))
    else $error("zero count did not wrap to full length");
  AST_TCR_HI_ZERO: assert property (
    (st_ff.rvalid && st_ff.raddr[3:2] == 2'h2) |-> st_ff.rdata[31:24] == 8'h00)
    else $error("count upper byte read nonzero");
  AST_CTL_HI_ZERO: assert property (
    (st_ff.rvalid && st_ff.raddr[3:2] == 2'h3) |-> st_ff.rdata[31:21] == 11'h0)
    else $error("control upper bits read nonzero");
  AST_ABSENT_BITS: assert property (
    !st_ff.ch[0].ctl[20] && !st_ff.ch[0].ctl[19] && !st_ff.ch[2].ctl[18] &&
    !st_ff.ch[3].ctl[16] && !st_ff.ch[1].ctl[20])
    else $error("absent control bit became set");
  AST_TE_NO_SET_BY_SW: assert property (
    $rose(st_ff.ch[0].ctl[1]) |-> $past(xfer_done_i[0]))
    else $error("flag set without a finished unit");
  AST_SRC_INC_BYTE: assert property (
    (xfer_done_i[0] && live[0] && st_ff.ch[0].ctl[15:3] == 13'h0200 &&
     !standby_i && !(do_wr && wmap && wch == 2'h0)) |=>
    st_ff.ch[0].source_address == $past(st_ff.ch[0].source_address) + 32'h00000001)
    else $error("source byte increment wrong");
  AST_DST_HELD_SGL: assert property (
    (xfer_done_i[0] && st_ff.ch[0].ctl[11:8] == 4'h2 &&
     !(do_wr && wmap && wch == 2'h0)) |=>
    st_ff.ch[0].destination_address == $past(st_ff.ch[0].destination_address))
    else $error("destination moved in single mode");
  AST_ACK_IDLE_LEVEL: assert property (
    (!rd_cycle_i[0] && !wr_cycle_i[0]) |=>
    acknowledge_strobe_o[0] == $past(st_ff.ch[0].ctl[16]))
    else $error("idle acknowledge level wrong");
  AST_ACK_WRITE_ONLY: assert property (
    (st_ff.ch[0].ctl[0] && st_ff.ch[0].ctl[17] && !st_ff.ch[0].ctl[16] &&
     st_ff.ch[0].ctl[11:8] == 4'h0 && rd_cycle_i[0] && !wr_cycle_i[0]) |=>
    !acknowledge_strobe_o[0])
    else $error("acknowledge in read cycle with write timing");
  AST_ACK_SINGLE: assert property (
    (st_ff.ch[0].ctl[0] && !st_ff.ch[0].ctl[16] &&
     st_ff.ch[0].ctl[11:8] == 4'h3 && rd_cycle_i[0]) |=>
    acknowledge_strobe_o[0])
    else $error("acknowledge missing in single mode");
  AST_WR_RESP: assert property (
    do_wr |=> s_axi_bvalid_o)
    else $error("write response missing");
  AST_WR_HOLD: assert property (
    (s_axi_bvalid_o && !s_axi_bready_i) |=>
    (s_axi_bvalid_o && $stable(s_axi_bresp_o)))
    else $error("write response dropped before taken");
  CV_TE_SET: cover property ($rose(st_ff.ch[0].ctl[1]));
  CV_TE_CLEAR: cover property ($fell(st_ff.ch[0].ctl[1]));
  CV_RELOAD: cover property (xfer_done_i[2] && stp_reload[2]);
  CV_ACCEPT: cover property ($changed(request_accepted_output_o[0]));
endmodule // dmc_channels
`default_nettype wire

//--- design/dmc_params.svh
// dmc: register offsets, field positions and masks of the dma channel block
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH
// ---------------------------------------------------------------
// address map
// ---------------------------------------------------------------
`define DMC_WIN_TAG 2'h3
`define DMC_REG_SAR 2'h0
`define DMC_REG_DAR 2'h1
`define DMC_REG_TCR 2'h2
`define DMC_REG_CTL 2'h3
`define DMC_RESP_OK 2'h0
`define DMC_RESP_ERR 2'h2
`define DMC_F_WIN 7:6
`define DMC_F_CH 5:4
`define DMC_F_REG 3:2
// ---------------------------------------------------------------
// channel control fields
// ---------------------------------------------------------------
`define DMC_B_DE 0
`define DMC_B_TE 1
`define DMC_B_DS 6
`define DMC_B_AL 16
`define DMC_B_AM 17
`define DMC_B_RL 18
`define DMC_B_RO 19
`define DMC_B_DI 20
`define DMC_F_TS 4:3
`define DMC_F_RS 11:8
`define DMC_F_SM 13:12
`define DMC_F_DM 15:14
// ---------------------------------------------------------------
// writable masks per channel group
// ---------------------------------------------------------------
`define DMC_MSK_BASE 32'h0000ff3d
`define DMC_MSK_EXT 32'h00070040
`define DMC_MSK_CH2 32'h00080000
`define DMC_MSK_CH3 32'h00100000
`define DMC_TCR_HI_ZERO 8'h00
`define DMC_CTL_RST 32'h00000000
// ---------------------------------------------------------------
// field codes
// ---------------------------------------------------------------
`define DMC_RS_EXT_DUAL 4'h0
`define DMC_RS_SGL_TO_DEV 4'h2
`define DMC_RS_SGL_FROM_DEV 4'h3
`define DMC_RS_AUTO 4'h4
`define DMC_SM_HOLD 2'h0
`define DMC_SM_INC 2'h1
`define DMC_SM_DEC 2'h2
`define DMC_TS_BYTE 2'h0
`define DMC_TS_WORD 2'h1
`define DMC_TS_LONG 2'h2
`define DMC_STEP_1 32'h00000001
`define DMC_STEP_2 32'h00000002
`define DMC_STEP_4 32'h00000004
`define DMC_STEP_0 32'h00000000
`define DMC_TCR_ONE 24'h000001
`define DMC_TCR_DEC 24'h000001
`define DMC_RELOAD_LAST 2'h3
`define DMC_INDIRECT_CH 3
`define DMC_RELOAD_CH 2
`define DMC_EXT_CHANNELS 2
`endif

//--- design/dmc_pkg.sv
// dmc: types shared by the dma channel register block
package dmc_pkg;
  typedef struct packed {
    logic [31:0] source_address;
    logic [31:0] destination_address;
    logic [23:0] tcr;
    logic [31:0] ctl;
    logic te_seen;
    logic ext_pend;
  } dmc_chan_type;
  typedef struct packed {
    dmc_chan_type [3:0] ch;
    logic [31:0] rl_sar;
    logic [1:0] rl_cnt;
    logic [1:0] req_s1;
    logic [1:0] req_s2;
    logic [1:0] req_s3;
    logic [1:0] ack;
    logic [1:0] request_accepted_output;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] raddr;
  } dmc_state_type;
endpackage

//--- design/dmc_step.sv
// dmc: next address and count of one channel after a transfer unit
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_step #(
  parameter int CH = 0
) (
  input wire logic [31:0] ctl_i,
  input wire logic [31:0] sar_i,
  input wire logic [31:0] dar_i,
  input wire logic [23:0] tcr_i,
  input wire logic reload_i,
  input wire logic [31:0] reload_sar_i,
  output logic [31:0] sar_o,
  output logic [31:0] dar_o,
  output logic [23:0] tcr_o,
  output logic last_o
);
  // ---------------------------------------------------------------
  // step arithmetic
  // ---------------------------------------------------------------
  function automatic logic [31:0] stepped(input logic [31:0] a,
      input logic [1:0] mode, input logic [31:0] sz);
    case (mode)
      `DMC_SM_INC: stepped = a + sz;
      `DMC_SM_DEC: stepped = a - sz;
      default: stepped = a;
    endcase
  endfunction
  logic [31:0] unit;
  logic [31:0] src_unit;
  logic [3:0] rs;
  logic dev_src;
  logic dev_dst;
  assign rs = ctl_i[`DMC_F_RS];
  // single-address roles exist only on the external channels
  assign dev_src = (CH < `DMC_EXT_CHANNELS) && (rs == `DMC_RS_SGL_FROM_DEV);
  assign dev_dst = (CH < `DMC_EXT_CHANNELS) && (rs == `DMC_RS_SGL_TO_DEV);
  // unit size from transfer size field
  always_comb begin
    case (ctl_i[`DMC_F_TS])
      `DMC_TS_BYTE: unit = `DMC_STEP_1;
      `DMC_TS_WORD: unit = `DMC_STEP_2;
      `DMC_TS_LONG: unit = `DMC_STEP_4;
      default: unit = `DMC_STEP_0;
    endcase
  end
  // indirect source walks the pointer table in longwords
  assign src_unit = (CH == `DMC_INDIRECT_CH && ctl_i[`DMC_B_DI]) ?
                    `DMC_STEP_4 : unit;
  // source counts unless the device itself is the source or a reload restores it
  always_comb begin
    if (dev_src) begin
      sar_o = sar_i;
    end else if (reload_i) begin
      sar_o = reload_sar_i;
    end else begin
      sar_o = stepped(sar_i, ctl_i[`DMC_F_SM], src_unit);
    end
  end
  // destination counts unless the device itself is the destination
  always_comb begin
    if (dev_dst) begin
      dar_o = dar_i;
    end else begin
      dar_o = stepped(dar_i, ctl_i[`DMC_F_DM], unit);
    end
  end
  // zero wraps to all ones, so zero means the full 2**24 units
  assign tcr_o = tcr_i - `DMC_TCR_DEC;
  assign last_o = (tcr_i == `DMC_TCR_ONE);
endmodule // dmc_step
`default_nettype wire

//--- design/dmc_unused_note.sv
// dmc: intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- verification/dmc_ext_dev.sv
// dmc: model of an external device requesting over the two pin channels
`timescale 1ns/1ps
`default_nettype none
module dmc_ext_dev (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] go_i,
  input wire logic [1:0] pol_i,
  input wire logic [1:0] accepted_i,
  output logic [1:0] req_b_o,
  output logic [7:0] hits_o
);
  logic [1:0] served;
  // request low once per go, released to pull-up level when accepted
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_b_o <= 2'h3;
      served <= 2'h0;
      hits_o <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!req_b_o[c] && (accepted_i[c] ^ pol_i[c])) begin
          req_b_o[c] <= 1'b1;
          served[c] <= 1'b1;
          hits_o <= hits_o + 8'h01;
        end else if (go_i[c] && !served[c]) begin
          req_b_o[c] <= 1'b0;
        end else if (!go_i[c]) begin
          served[c] <= 1'b0;
        end
      end
    end
  end
endmodule // dmc_ext_dev
`default_nettype wire

//--- verification/dmc_channels_tb.sv
// dmc: self-checking testbench of the dma channel register block
`timescale 1ns/1ps
`default_nettype none
module dmc_channels_tb;
  logic clk_i, rst_b_i, standby_i, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, hits;
  logic [1:0] bresp, rresp, rr, req_b, ack, request_accepted_output, go, br;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb, rdc, wrc, done, creq;
  logic [3:0][31:0] src, dst;
  logic [31:0] msk [4] = '{32'h0007ff7d, 32'h0007ff7d, 32'h0008ff3d,
                           32'h0010ff3d};
  int err_count, tests_run, n;
  dmc_channels i_dmc_channels (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .standby_i(standby_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .external_transfer_request_b_i(req_b),
    .acknowledge_strobe_o(ack), .request_accepted_output_o(request_accepted_output),
    .periph_req_i(4'h0), .rd_cycle_i(rdc), .wr_cycle_i(wrc),
    .xfer_done_i(done), .chan_req_o(creq), .src_addr_o(src),
    .dst_addr_o(dst));
  dmc_ext_dev i_dmc_ext_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go),
    .pol_i(2'h0), .accepted_i(request_accepted_output), .req_b_o(req_b), .hits_o(hits));
  // byte address of register o of channel c
  function automatic logic [7:0] ra(input int c, input logic [3:0] o);
    return 8'hc0 + 8'(c * 16) + {4'h0, o};
  endfunction
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // axi write: release each channel once taken, hold bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (tb !== 1'b1) begin
      @(negedge clk_i);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      br = bresp;
      @(posedge clk_i);
      if (ta === 1'b1) awvalid <= 1'b0;
      if (tw === 1'b1) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  // axi read: data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (tr !== 1'b1) begin
      @(negedge clk_i);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ta === 1'b1) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // one finished unit on the masked channels, then settle
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i) done <= m;
    @(posedge clk_i) done <= 4'h0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // one bus cycle on channel 0, acknowledge level checked a cycle later
  task automatic cyc(input logic r, input logic w, input logic e);
    @(posedge clk_i);
    rdc <= {3'h0, r};
    wrc <= {3'h0, w};
    @(posedge clk_i);
    @(negedge clk_i) chk("acknowledge", {31'h0, e}, {31'h0, ack[0]});
    @(posedge clk_i);
    rdc <= 4'h0;
    wrc <= 4'h0;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    err_count++;
    test_done;
  end
  initial begin
    {rst_b_i, standby_i, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, rdc, wrc, done, go} = '0;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(ra(c, 4'hc), rv, rr);
      chk("ctl reset", 32'h0, rv);
      wr(ra(c, 4'hc), 32'hffffffff);
      rd(ra(c, 4'hc), rv, rr);
      chk("ctl bits", msk[c], rv);
      wr(ra(c, 4'hc), 32'h0);
    end
    wr(ra(0, 4'h8), 32'hffffffff);
    rd(ra(0, 4'h8), rv, rr);
    chk("count top", 32'h00ffffff, rv);
    // ch0: byte steps, single-address roles, flag and zero count
    wr(ra(0, 4'h0), 32'h10);
    wr(ra(0, 4'h4), 32'h20);
    wr(ra(0, 4'h8), 32'h3);
    wr(ra(0, 4'hc), 32'h1001);
    pulse(4'h1);
    chk("src inc", 32'h11, src[0]);
    wr(ra(0, 4'hc), 32'h5201);
    pulse(4'h1);
    chk("dst held", 32'h20, dst[0]);
    wr(ra(0, 4'hc), 32'h5301);
    pulse(4'h1);
    chk("src held", 32'h12, src[0]);
    chk("dst inc", 32'h21, dst[0]);
    wr(ra(0, 4'hc), 32'h5301);
    rd(ra(0, 4'hc), rv, rr);
    chk("flag unread", 32'h5303, rv);
    pulse(4'h1);
    chk("dst ended", 32'h21, dst[0]);
    wr(ra(0, 4'hc), 32'h5301);
    pulse(4'h1);
    rd(ra(0, 4'h8), rv, rr);
    chk("count wrap", 32'h00ffffff, rv);
    wr(ra(2, 4'h0), 32'h100);
    wr(ra(2, 4'h4), 32'h200);
    wr(ra(2, 4'h8), 32'h2);
    wr(ra(2, 4'hc), 32'h1009);
    pulse(4'h4);
    chk("src", 32'h102, src[2]);
    chk("dst", 32'h200, dst[2]);
    rd(ra(2, 4'h8), rv, rr);
    chk("count", 32'h1, rv);
    pulse(4'h4);
    rd(ra(2, 4'hc), rv, rr);
    chk("end flag", 32'h100b, rv);
    wr(ra(2, 4'hc), 32'h1009);
    rd(ra(2, 4'hc), rv, rr);
    chk("flag clear", 32'h1009, rv);
    // fourth unit on ch2 restores the written source
    wr(ra(2, 4'h0), 32'h100);
    wr(ra(2, 4'hc), 32'h81009);
    repeat (4) pulse(4'h4);
    chk("reload", 32'h100, src[2]);
    for (int k = 0; k < 6; k++) begin
      wr(ra(3, 4'h0), 32'h1000);
      wr(ra(3, 4'h8), 32'h0);
      wr(ra(3, 4'hc), 32'h1 | ((k < 3 ? 32'h1 : 32'h2) << 12) |
         (32'(k % 3) << 3));
      pulse(4'h8);
      rv = (k < 3) ? 32'h1000 + (32'h1 << (k % 3)) :
           32'h1000 - (32'h1 << (k % 3));
      chk("step", rv, src[3]);
      rd(ra(3, 4'h8), rv, rr);
      chk("count max", 32'h00ffffff, rv);
    end
    wr(ra(3, 4'hc), 32'h101001);
    pulse(4'h8);
    chk("indirect step", 32'h1000, src[3]);
    wr(ra(0, 4'hc), 32'h00001);
    cyc(1'b1, 1'b0, 1'b1);
    wr(ra(0, 4'hc), 32'h10001);
    cyc(1'b1, 1'b0, 1'b0);
    cyc(1'b0, 1'b1, 1'b1);
    wr(ra(0, 4'hc), 32'h30001);
    cyc(1'b0, 1'b1, 1'b0);
    wr(ra(0, 4'hc), 32'h30201);
    cyc(1'b1, 1'b0, 1'b0);
    wr(ra(0, 4'hc), 32'h20001);
    cyc(1'b1, 1'b0, 1'b0);
    wr(ra(0, 4'hc), 32'h20301);
    cyc(1'b1, 1'b0, 1'b1);
    wr(ra(1, 4'hc), 32'h1);
    go <= 2'h2;
    n = 0;
    while (hits === 8'h0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    @(negedge clk_i) chk("accepted", 32'h1, {24'h0, hits});
    chk("request", 32'h1, {31'h0, creq[1]});
    @(posedge clk_i) go <= 2'h0;
    wr(ra(1, 4'hc), 32'h40000);
    @(negedge clk_i) chk("accepted level", 32'h1, {31'h0, request_accepted_output[1]});
    rd(8'h10, rv, rr);
    chk("unmapped resp", 32'h2, {30'h0, rr});
    chk("unmapped data", 32'h0, rv);
    wr(8'h10, 32'h1);
    chk("unmapped bresp", 32'h2, {30'h0, br});
    wr(ra(0, 4'h0), 32'h44);
    chk("write resp", 32'h0, {30'h0, br});
    @(posedge clk_i) standby_i <= 1'b1;
    @(posedge clk_i) standby_i <= 1'b0;
    rd(ra(0, 4'hc), rv, rr);
    chk("ctl standby", 32'h0, rv);
    rd(ra(0, 4'h0), rv, rr);
    chk("src standby", 32'h44, rv);
    test_done;
  end
endmodule // dmc_channels_tb
`default_nettype wire
